//--- pkg/atfb_pkg.sv
package atfb_pkg;

    // Descriptor command codes and field values.
    localparam logic [3:0]  OP_FINAL      = 4'h1;
    localparam logic [2:0]  FMT_BUFFER    = 3'h0;
    localparam logic [1:0]  RPT_ALWAYS    = 2'b11;
    localparam logic [1:0]  RPT_FAIL      = 2'b01;
    localparam logic [1:0]  RPT_NEVER     = 2'b00;
    localparam logic [3:0]  ACK_COMPLETE  = 4'h1;
    localparam logic [3:0]  ACK_PENDING   = 4'h2;
    localparam logic [3:0]  NEXT_NONE     = 4'h0;
    localparam logic [3:0]  NEXT_MIN      = 4'h2;
    localparam logic [3:0]  NEXT_MAX      = 4'h8;

    // Field positions in the descriptor quadlets.
    localparam int OP_LSB     = 28;
    localparam int UPD_BIT    = 27;
    localparam int FMT_LSB    = 24;
    localparam int RPT_LSB    = 20;
    localparam int LEN_LSB    = 0;
    localparam int PTR_LSB    = 4;
    localparam int CNT_LSB    = 0;
    localparam int CMPL_LSB   = 16;
    localparam int MARK_LSB   = 0;
    localparam int SEC_BITS   = 3;

    // Quadlet indices and byte offsets inside a descriptor.
    localparam logic [1:0]  W_HDR         = 2'h0;
    localparam logic [1:0]  W_BUF         = 2'h1;
    localparam logic [1:0]  W_LINK        = 2'h2;
    localparam logic [1:0]  W_STAT        = 2'h3;
    localparam logic [31:0] HDR_OFS       = 32'h0000_0000;
    localparam logic [31:0] STAT_OFS      = 32'h0000_000C;
    localparam logic [31:0] WORD_BYTES    = 32'h0000_0004;

    // Register offsets, bit positions and reset values.
    localparam logic [4:0]  REG_CTRL      = 5'h00;
    localparam logic [4:0]  REG_PTR       = 5'h04;
    localparam logic [4:0]  REG_CHAN      = 5'h08;
    localparam logic [4:0]  REG_STATUS    = 5'h0C;
    localparam logic [4:0]  REG_DONE      = 5'h10;
    localparam int CTRL_RUN    = 0;
    localparam int CTRL_START  = 1;
    localparam int ST_BUSY     = 0;
    localparam int ST_ERR      = 1;
    localparam int ST_END      = 2;
    localparam int ST_ACK_LSB  = 4;
    localparam int ST_NEXT_LSB = 8;
    localparam logic        RUN_RST       = 1'b0;
    localparam logic [31:0] PTR_RST       = 32'h0000_0000;
    localparam logic [15:0] CHAN_RST      = 16'h0000;

    typedef enum logic [3:0] {
        S_IDLE, S_FETCH, S_CHECK, S_DATA, S_CLOSE, S_WAIT_ACK,
        S_WB_STAT, S_WB_RES, S_REPORT, S_NEXT
    } atfb_state_t;

endpackage : atfb_pkg

//--- core/atfb_unpack.sv
module atfb_unpack (
    // Clock and reset.
    input  wire logic        i_clock,
    input  wire logic        i_rst_n,
    // Word load.
    input  wire logic        i_load,
    input  wire logic [31:0] i_word,
    input  wire logic [1:0]  i_skip,
    input  wire logic [2:0]  i_count,
    // Byte stream.
    input  wire logic        i_ready,
    output logic             o_valid,
    output logic      [7:0]  o_byte,
    output logic             o_busy
);

    logic [31:0] word;
    logic [1:0]  idx;
    logic [2:0]  left;

    // Bytes leave lowest address first; a load is only made while idle.
    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            word    <= 32'h0000_0000;
            idx     <= 2'h0;
            left    <= 3'h0;
            o_valid <= 1'b0;
            o_byte  <= 8'h00;
        end else if (i_load) begin
            word <= i_word;
            idx  <= i_skip;
            left <= i_count;
        end else if (left != 3'h0 && (!o_valid || i_ready)) begin
            o_valid <= 1'b1;
            o_byte  <= word[{idx, 3'h0} +: 8];
            idx     <= idx + 2'h1;
            left    <= left - 3'h1;
        end else if (i_ready) begin
            o_valid <= 1'b0;
        end
    end

    assign o_busy = (left != 3'h0) || o_valid;

endmodule : atfb_unpack

//--- core/atfb_core.sv
//Contract
// [RULE1] Opcode field is four bits; value 4'h1 is the final buffer command.
// [RULE2] Format field is three bits and holds zero: payload in separate buffer.
// [RULE3] Update flag set writes back completion word and residual; clear leaves them.
// [RULE4] Report mode 2'b11 interrupts on every completion.
// [RULE5] Report mode 2'b01 interrupts unless ack was complete or pending.
// [RULE6] Report mode 2'b00 never interrupts on completion.
// [RULE7] Software never programs report mode 2'b10.
// [RULE8] Software always programs flow control field to 2'b11.
// [RULE9] Exactly byte_request_len bytes from buffer_pointer go into the FIFO.
// [RULE10] buffer_pointer is a 32-bit host address of the transmit data.
// [RULE11] Next pointer holds upper 28 bits; low four address bits are zero.
// [RULE12] Software gives a valid next pointer whenever next count is nonzero.
// [RULE13] Next count gives the 16-byte blocks of the next packet, fetched together.
// [RULE14] Next count zero ends the list; otherwise only 2 through 8 are legal.
// [RULE15] Immediate descriptors count as two blocks, others as one.
// [RULE16] Completion word receives channel_control_word bits 15 to 0.
// [RULE17] cycle_mark is three low second bits then thirteen cycle number bits.
// [RULE18] Request packets with update flag get their transmission time in cycle_mark.
// [RULE19] Response packets leave cycle_mark of this descriptor unused.
// [RULE20] Bytes moved by this command end and close the current packet.
// [RULE21] Bytes are read from host memory into the transmit FIFO.
// [RULE22] The descriptor is 16 bytes and starts on a 16-byte boundary.
// [RULE23] Nonzero next count fetches the next blocks; zero stops the list.
//
// Local design decisions: strobed register access and the address map.
module atfb_core #(
    parameter int DONE_W = 16
) (
    // Clock and reset.
    input  wire logic        i_clock,
    input  wire logic        i_rst_b,
    // Register port.
    input  wire logic [4:0]  i_reg_addr,
    input  wire logic [31:0] i_reg_wdata,
    input  wire logic        i_reg_wr,
    input  wire logic        i_reg_rd,
    output logic      [31:0] o_reg_rdata,
    // Host memory master.
    output logic             o_mem_req,
    output logic             o_mem_we,
    output logic      [31:0] o_mem_addr,
    output logic      [31:0] o_mem_wdata,
    input  wire logic        i_mem_gnt,
    input  wire logic        i_mem_rvalid,
    input  wire logic [31:0] i_mem_rdata,
    // Transmit FIFO.
    output logic             o_tx_valid,
    output logic      [7:0]  o_tx_byte,
    output logic             o_tx_close,
    input  wire logic        i_tx_ready,
    // Link status.
    input  wire logic        i_ack_valid,
    input  wire logic [3:0]  i_ack_code,
    input  wire logic        i_response,
    input  wire logic [6:0]  i_cycle_seconds,
    input  wire logic [12:0] i_cycle_number,
    // Completion events and next descriptor block.
    output logic             o_cmpl_irq,
    output logic             o_list_end,
    output logic             o_blk_valid,
    output logic      [31:0] o_blk_word
);

    if (DONE_W < 1 || DONE_W > 32) begin : g_bad_width
        $error("DONE_W must lie between 1 and 32.");
    end

    logic                 rst_q1;
    logic                 rst_n;
    atfb_pkg::atfb_state_t state;
    logic [31:0]          desc_q [4];
    logic                 run;
    logic                 start_req;
    logic [15:0]          chan_ctrl;
    logic [31:0]          desc_ptr;
    logic [31:0]          data_addr;
    logic [16:0]          remain;
    logic                 first;
    logic                 rd_wait;
    logic [5:0]           wcnt;
    logic [3:0]           blocks;
    logic [3:0]           ack_q;
    logic                 resp_q;
    logic [15:0]          stamp;
    logic                 err;
    logic                 end_seen;
    logic [DONE_W-1:0]    done_cnt;
    logic                 unp_busy;
    logic                 unp_load;
    logic [1:0]           unp_skip;
    logic [2:0]           unp_avail;
    logic [2:0]           unp_take;
    logic                 irq_due;
    logic                 count_ok;
    logic                 can_issue;

    // Descriptor fields.
    logic [3:0]  op;
    logic        upd;
    logic [2:0]  fmt;
    logic [1:0]  rpt;
    logic [15:0] req_len;
    logic [31:0] buf_ptr;
    logic [27:0] next_ptr;
    logic [3:0]  nxt_cnt;

    // Reset is released through two flip-flops.
    always_ff @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            rst_q1 <= 1'b0;
            rst_n  <= 1'b0;
        end else begin
            rst_q1 <= 1'b1;
            rst_n  <= rst_q1;
        end
    end

    assign op       = desc_q[atfb_pkg::W_HDR][atfb_pkg::OP_LSB +: 4]; // [RULE1]
    assign upd      = desc_q[atfb_pkg::W_HDR][atfb_pkg::UPD_BIT];
    assign fmt      = desc_q[atfb_pkg::W_HDR][atfb_pkg::FMT_LSB +: 3]; // [RULE2]
    assign rpt      = desc_q[atfb_pkg::W_HDR][atfb_pkg::RPT_LSB +: 2];
    assign req_len  = desc_q[atfb_pkg::W_HDR][atfb_pkg::LEN_LSB +: 16];
    assign buf_ptr  = desc_q[atfb_pkg::W_BUF]; // [RULE10]
    assign next_ptr = desc_q[atfb_pkg::W_LINK][atfb_pkg::PTR_LSB +: 28];
    assign nxt_cnt  = desc_q[atfb_pkg::W_LINK][atfb_pkg::CNT_LSB +: 4];

    // Zero ends the list; software has already counted immediate ones twice.
    assign count_ok = (nxt_cnt == atfb_pkg::NEXT_NONE) || // [RULE14]
                      (nxt_cnt >= atfb_pkg::NEXT_MIN && nxt_cnt <= atfb_pkg::NEXT_MAX); // [RULE15]

    always_comb begin
        case (rpt)
            atfb_pkg::RPT_ALWAYS: irq_due = 1'b1; // [RULE4]
            atfb_pkg::RPT_FAIL:   irq_due = ack_q != atfb_pkg::ACK_COMPLETE &&
                                            ack_q != atfb_pkg::ACK_PENDING; // [RULE5]
            default:              irq_due = 1'b0; // [RULE6]
        endcase
    end

    // First word skips the unaligned start; each word carries at most the remainder.
    assign unp_skip  = first ? buf_ptr[1:0] : 2'h0;
    assign unp_avail = 3'h4 - {1'b0, unp_skip};
    assign unp_take  = (remain < {14'h0, unp_avail}) ? remain[2:0] : unp_avail; // [RULE9]
    assign unp_load  = (state == atfb_pkg::S_DATA) && i_mem_rvalid;
    assign can_issue = !o_mem_req && !rd_wait;

    atfb_unpack u_unpack (
        .i_clock (i_clock),
        .i_rst_n (rst_n),
        .i_load  (unp_load),
        .i_word  (i_mem_rdata),
        .i_skip  (unp_skip),
        .i_count (unp_take),
        .i_ready (i_tx_ready),
        .o_valid (o_tx_valid),
        .o_byte  (o_tx_byte),
        .o_busy  (unp_busy)
    );

    // Control register and channel control word.
    always_ff @(posedge i_clock or negedge rst_n) begin
        if (!rst_n) begin
            run       <= atfb_pkg::RUN_RST;
            start_req <= 1'b0;
            chan_ctrl <= atfb_pkg::CHAN_RST;
        end else begin
            start_req <= 1'b0;
            if (i_reg_wr && i_reg_addr == atfb_pkg::REG_CTRL) begin
                run       <= i_reg_wdata[atfb_pkg::CTRL_RUN];
                start_req <= i_reg_wdata[atfb_pkg::CTRL_START];
            end
            if (i_reg_wr && i_reg_addr == atfb_pkg::REG_CHAN) begin
                chan_ctrl <= i_reg_wdata[15:0];
            end
        end
    end

    // Register read data, valid in the cycle after the read strobe.
    always_ff @(posedge i_clock or negedge rst_n) begin
        if (!rst_n) begin
            o_reg_rdata <= 32'h0000_0000;
        end else begin
            o_reg_rdata <= 32'h0000_0000;
            if (i_reg_rd) begin
                case (i_reg_addr)
                    atfb_pkg::REG_CTRL: o_reg_rdata[atfb_pkg::CTRL_RUN] <= run;
                    atfb_pkg::REG_PTR:  o_reg_rdata <= desc_ptr;
                    atfb_pkg::REG_CHAN: o_reg_rdata[15:0] <= chan_ctrl;
                    atfb_pkg::REG_STATUS: begin
                        o_reg_rdata[atfb_pkg::ST_BUSY] <= state != atfb_pkg::S_IDLE;
                        o_reg_rdata[atfb_pkg::ST_ERR] <= err;
                        o_reg_rdata[atfb_pkg::ST_END] <= end_seen;
                        o_reg_rdata[atfb_pkg::ST_ACK_LSB +: 4] <= ack_q;
                        o_reg_rdata[atfb_pkg::ST_NEXT_LSB +: 4] <= blocks;
                    end
                    atfb_pkg::REG_DONE: o_reg_rdata[DONE_W-1:0] <= done_cnt;
                    default: o_reg_rdata <= 32'h0000_0000;
                endcase
            end
        end
    end

    // Descriptor quadlets as they arrive.
    always_ff @(posedge i_clock) begin
        if (state == atfb_pkg::S_FETCH && i_mem_rvalid) begin
            desc_q[wcnt[1:0]] <= i_mem_rdata;
        end
    end

    // Descriptor sequencer and host memory master.
    always_ff @(posedge i_clock or negedge rst_n) begin
        if (!rst_n) begin
            state       <= atfb_pkg::S_IDLE;
            o_mem_req   <= 1'b0;
            o_mem_we    <= 1'b0;
            o_mem_addr  <= 32'h0000_0000;
            o_mem_wdata <= 32'h0000_0000;
            o_tx_close  <= 1'b0;
            o_cmpl_irq  <= 1'b0;
            o_list_end  <= 1'b0;
            o_blk_valid <= 1'b0;
            o_blk_word  <= 32'h0000_0000;
            rd_wait     <= 1'b0;
            wcnt        <= 6'h00;
            desc_ptr    <= atfb_pkg::PTR_RST;
            data_addr   <= 32'h0000_0000;
            remain      <= 17'h0_0000;
            first       <= 1'b0;
            blocks      <= 4'h0;
            ack_q       <= 4'h0;
            resp_q      <= 1'b0;
            stamp       <= 16'h0000;
            err         <= 1'b0;
            end_seen    <= 1'b0;
            done_cnt    <= '0;
        end else begin
            o_tx_close  <= 1'b0;
            o_cmpl_irq  <= 1'b0;
            o_list_end  <= 1'b0;
            o_blk_valid <= 1'b0;
            if (o_mem_req && i_mem_gnt) begin
                o_mem_req <= 1'b0;
                rd_wait   <= !o_mem_we;
            end
            if (i_mem_rvalid) begin
                rd_wait <= 1'b0;
            end
            case (state)
                atfb_pkg::S_IDLE: begin
                    if (i_reg_wr && i_reg_addr == atfb_pkg::REG_PTR) begin
                        desc_ptr <= {i_reg_wdata[31:4], 4'h0}; // [RULE22]
                    end
                    if (start_req && run) begin
                        err      <= 1'b0;
                        end_seen <= 1'b0;
                        wcnt     <= 6'h00;
                        state    <= atfb_pkg::S_FETCH;
                    end
                end
                atfb_pkg::S_FETCH: begin
                    if (can_issue) begin
                        o_mem_req  <= 1'b1;
                        o_mem_we   <= 1'b0;
                        o_mem_addr <= desc_ptr + {24'h00_0000, wcnt, 2'b00}; // [RULE22]
                    end
                    if (i_mem_rvalid) begin
                        wcnt <= wcnt + 6'h01;
                        if (wcnt[1:0] == atfb_pkg::W_STAT) begin
                            state <= atfb_pkg::S_CHECK;
                        end
                    end
                end
                atfb_pkg::S_CHECK: begin
                    if (op != atfb_pkg::OP_FINAL || fmt != atfb_pkg::FMT_BUFFER || !count_ok) begin
                        err   <= 1'b1; // [RULE1] [RULE2] [RULE14]
                        state <= atfb_pkg::S_IDLE;
                    end else begin
                        data_addr <= {buf_ptr[31:2], 2'b00}; // [RULE10]
                        remain    <= {1'b0, req_len};
                        first     <= 1'b1;
                        state     <= atfb_pkg::S_DATA;
                    end
                end
                atfb_pkg::S_DATA: begin
                    if (remain == 17'h0_0000) begin
                        state <= atfb_pkg::S_CLOSE;
                    end else if (can_issue && !unp_busy) begin
                        o_mem_req  <= 1'b1; // [RULE21]
                        o_mem_we   <= 1'b0;
                        o_mem_addr <= data_addr;
                    end
                    if (i_mem_rvalid) begin
                        remain    <= remain - {14'h0000, unp_take}; // [RULE9]
                        data_addr <= data_addr + atfb_pkg::WORD_BYTES;
                        first     <= 1'b0;
                    end
                end
                atfb_pkg::S_CLOSE: begin
                    if (!unp_busy) begin
                        o_tx_close <= 1'b1; // [RULE20]
                        state      <= atfb_pkg::S_WAIT_ACK;
                    end
                end
                atfb_pkg::S_WAIT_ACK: begin
                    if (i_ack_valid) begin
                        ack_q  <= i_ack_code;
                        resp_q <= i_response;
                        stamp  <= {i_cycle_seconds[atfb_pkg::SEC_BITS-1:0], // [RULE17]
                                   i_cycle_number};
                        state  <= upd ? atfb_pkg::S_WB_STAT : atfb_pkg::S_REPORT; // [RULE3]
                    end
                end
                atfb_pkg::S_WB_STAT: begin
                    if (!o_mem_req) begin
                        o_mem_req   <= 1'b1;
                        o_mem_we    <= 1'b1;
                        o_mem_addr  <= desc_ptr + atfb_pkg::STAT_OFS;
                        o_mem_wdata <= {chan_ctrl, resp_q ? // [RULE16] [RULE19]
                                        desc_q[atfb_pkg::W_STAT][15:0] : stamp}; // [RULE18]
                    end else if (i_mem_gnt) begin
                        state <= atfb_pkg::S_WB_RES;
                    end
                end
                atfb_pkg::S_WB_RES: begin
                    if (!o_mem_req) begin
                        o_mem_req   <= 1'b1; // [RULE3]
                        o_mem_we    <= 1'b1;
                        o_mem_addr  <= desc_ptr + atfb_pkg::HDR_OFS;
                        o_mem_wdata <= {desc_q[atfb_pkg::W_HDR][31:16], remain[15:0]};
                    end else if (i_mem_gnt) begin
                        state <= atfb_pkg::S_REPORT;
                    end
                end
                atfb_pkg::S_REPORT: begin
                    o_cmpl_irq <= irq_due;
                    done_cnt   <= done_cnt + 1'b1;
                    if (nxt_cnt == atfb_pkg::NEXT_NONE) begin
                        o_list_end <= 1'b1; // [RULE23]
                        end_seen   <= 1'b1;
                        state      <= atfb_pkg::S_IDLE;
                    end else begin
                        desc_ptr <= {next_ptr, 4'h0}; // [RULE11]
                        blocks   <= nxt_cnt; // [RULE13]
                        wcnt     <= 6'h00;
                        state    <= atfb_pkg::S_NEXT;
                    end
                end
                atfb_pkg::S_NEXT: begin
                    if (can_issue) begin
                        o_mem_req  <= 1'b1;
                        o_mem_we   <= 1'b0;
                        o_mem_addr <= desc_ptr + {24'h00_0000, wcnt, 2'b00}; // [RULE13]
                    end
                    if (i_mem_rvalid) begin
                        o_blk_valid <= 1'b1;
                        o_blk_word  <= i_mem_rdata;
                        wcnt        <= wcnt + 6'h01;
                        if (wcnt == {blocks - 4'h1, 2'b11}) begin
                            state <= atfb_pkg::S_IDLE;
                        end
                    end
                end
                default: state <= atfb_pkg::S_IDLE;
            endcase
        end
    end

    // Checks.
    logic [16:0] sent;

    always_ff @(posedge i_clock or negedge rst_n) begin
        if (!rst_n) begin
            sent <= 17'h0_0000;
        end else if (state == atfb_pkg::S_CHECK) begin
            sent <= 17'h0_0000;
        end else if (o_tx_valid && i_tx_ready) begin
            sent <= sent + 17'h0_0001;
        end
    end

    default clocking cb @(posedge i_clock); endclocking
    default disable iff (!rst_n);

    sequence ack_taken_s;
        state == atfb_pkg::S_WAIT_ACK && i_ack_valid;
    endsequence

    sequence report_s;
        state == atfb_pkg::S_REPORT;
    endsequence

    bad_opcode_a: assert property ( // [RULE1]
        state == atfb_pkg::S_CHECK && op != atfb_pkg::OP_FINAL
        |=> state == atfb_pkg::S_IDLE && err)
        else $error("Wrong opcode was not refused.");

    bad_format_a: assert property ( // [RULE2]
        state == atfb_pkg::S_CHECK && fmt != atfb_pkg::FMT_BUFFER |=> err)
        else $error("Wrong format code was not refused.");

    no_update_a: assert property ( // [RULE3]
        ack_taken_s ##0 !upd |=> report_s ##1 !o_mem_req)
        else $error("Write-back done with update flag clear.");

    always_irq_a: assert property ( // [RULE4]
        report_s ##0 rpt == atfb_pkg::RPT_ALWAYS |=> o_cmpl_irq)
        else $error("Completion interrupt missing in always mode.");

    ack_irq_a: assert property ( // [RULE5]
        report_s ##0 rpt == atfb_pkg::RPT_FAIL |=> o_cmpl_irq ==
        (ack_q != atfb_pkg::ACK_COMPLETE && ack_q != atfb_pkg::ACK_PENDING))
        else $error("Interrupt does not follow the acknowledge.");

    never_irq_a: assert property ( // [RULE6]
        report_s ##0 rpt == atfb_pkg::RPT_NEVER |=> !o_cmpl_irq)
        else $error("Interrupt raised in never mode.");

    byte_count_a: assert property ( // [RULE9]
        o_tx_close |-> sent == {1'b0, req_len})
        else $error("Byte count differs from request length.");

    stat_word_a: assert property ( // [RULE16]
        state == atfb_pkg::S_WB_STAT && o_mem_req |-> o_mem_we &&
        o_mem_addr == desc_ptr + atfb_pkg::STAT_OFS && o_mem_wdata[31:16] == chan_ctrl)
        else $error("Completion word write is wrong.");

    stamp_take_a: assert property ( // [RULE17]
        ack_taken_s |=> stamp[12:0] == $past(i_cycle_number) &&
        stamp[15:13] == 3'($past(i_cycle_seconds)))
        else $error("cycle_mark not taken from the cycle timer.");

    list_end_a: assert property ( // [RULE23]
        report_s ##0 nxt_cnt == atfb_pkg::NEXT_NONE |=> state == atfb_pkg::S_IDLE && o_list_end)
        else $error("List did not stop at next count zero.");

endmodule : atfb_core

//--- bench/atfb_mem_model.sv
module atfb_mem_model (
    // Clock and stall control.
    input  wire logic        i_clock,
    input  wire logic        i_slow,
    // Memory port.
    input  wire logic        i_req,
    input  wire logic        i_we,
    input  wire logic [31:0] i_addr,
    input  wire logic [31:0] i_wdata,
    output logic             o_gnt,
    output logic             o_rvalid,
    output logic      [31:0] o_rdata
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [31:0] m [64];
    logic        odd = 1'b0;
    initial o_rvalid = 1'b0;
    initial o_rdata = 32'h0000_0000;
    assign o_gnt = i_req & ~(i_slow & odd);
    always @(posedge i_clock) begin
        odd <= ~odd;
        o_rvalid <= i_req & o_gnt & ~i_we;
        // Idle read data inverts its previous value every cycle.
        o_rdata <= (i_req & o_gnt & ~i_we) ? m[i_addr[7:2]] : ~o_rdata;
        if (i_req && o_gnt && i_we) begin
            m[i_addr[7:2]] <= i_wdata;
        end
    end
endmodule : atfb_mem_model

//--- bench/test_async_tx_final_buffer_descriptor.sv
module test_async_tx_final_buffer_descriptor;
    timeunit 1ns;
    timeprecision 1ps;
    logic i_clock = 0, i_rst_b = 0, wr_s = 0, rd_s = 0, ackv = 0, slow = 0, rdy = 1, resp = 0;
    logic [4:0] addr = 5'h00;
    logic [3:0] ackc = 4'h0;
    logic [31:0] wd = 32'h0, rdata, ma, mw, mr, blkw;
    logic req, we, gnt, rv, tv, cls, irq, lend, bv;
    logic [7:0] tb;
    logic [7:0] got [$];
    int fails = 0, checks_done = 0, irqs, ends, blks, closes;
    always #5 i_clock = ~i_clock;
    atfb_core dut_u (.i_clock(i_clock), .i_rst_b(i_rst_b), .i_reg_addr(addr),
        .i_reg_wdata(wd), .i_reg_wr(wr_s), .i_reg_rd(rd_s), .o_reg_rdata(rdata),
        .o_mem_req(req), .o_mem_we(we), .o_mem_addr(ma), .o_mem_wdata(mw), .i_mem_gnt(gnt),
        .i_mem_rvalid(rv), .i_mem_rdata(mr), .o_tx_valid(tv), .o_tx_byte(tb),
        .o_tx_close(cls), .i_tx_ready(rdy), .i_ack_valid(ackv), .i_ack_code(ackc),
        .i_response(resp), .i_cycle_seconds(7'h15), .i_cycle_number(13'h0ABC),
        .o_cmpl_irq(irq), .o_list_end(lend), .o_blk_valid(bv), .o_blk_word(blkw));
    atfb_mem_model mem_u (.i_clock(i_clock), .i_slow(slow), .i_req(req), .i_we(we),
        .i_addr(ma), .i_wdata(mw), .o_gnt(gnt), .o_rvalid(rv), .o_rdata(mr));
    always @(posedge i_clock) begin
        rdy <= ~slow | ~rdy;
        if (tv && rdy) got.push_back(tb);
        irqs <= irqs + int'(irq);
        ends <= ends + int'(lend);
        blks <= blks + int'(bv);
        closes <= closes + int'(cls);
    end
    task chk(input logic [31:0] g, input logic [31:0] e);
        checks_done++;
        if (g !== e) begin
            fails++;
            $display("wrong value at %0t: got %h expected %h", $time, g, e);
        end
    endtask : chk
    task wr(input logic [4:0] a, input logic [31:0] d);
        @(posedge i_clock) begin addr <= a; wd <= d; wr_s <= 1'b1; end
        @(posedge i_clock) wr_s <= 1'b0;
    endtask : wr
    task rd(input logic [4:0] a, input logic [31:0] e);
        @(posedge i_clock) begin addr <= a; rd_s <= 1'b1; end
        @(posedge i_clock) rd_s <= 1'b0;
        #1 chk(rdata, e);
    endtask : rd
    task run(input logic [31:0] q0, input logic [31:0] q2, input logic [3:0] ack, input int n);
        #1;
        mem_u.m[0] = q0;
        mem_u.m[1] = 32'h0000_0040;
        mem_u.m[2] = q2;
        mem_u.m[3] = 32'hFFFF_0000;
        mem_u.m[16] = 32'h4433_2211;
        got.delete();
        {irqs, ends, blks, closes} = '0;
        wr(atfb_pkg::REG_PTR, 32'h0000_0000);
        wr(atfb_pkg::REG_CTRL, 32'h0000_0003);
        for (int i = 0; i < 300 && closes == 0; i++) @(posedge i_clock);
        @(posedge i_clock) begin ackv <= 1'b1; ackc <= ack; end
        @(posedge i_clock) ackv <= 1'b0;
        for (int i = 0; i < 300 && ends + blks < n; i++) @(posedge i_clock);
        repeat (4) @(posedge i_clock);
        chk(ends + blks, n);
    endtask : run
    task sc_update;
        wr(atfb_pkg::REG_CHAN, 32'h0000_1234);
        run(32'h183C_0003, 32'h0000_0000, atfb_pkg::ACK_COMPLETE, 1);
        chk(got.size(), 3);
        chk({8'h00, got[0], got[1], got[2]}, 32'h0011_2233);
        chk(closes, 1);
        chk(irqs, 1);
        chk(ends, 1);
        chk(mem_u.m[3], 32'h1234_AABC);
        chk(mem_u.m[0], 32'h183C_0000);
        rd(atfb_pkg::REG_STATUS, 32'h0000_0014);
        rd(5'h1C, 32'h0);
    endtask : sc_update
    task sc_no_update;
        slow <= 1'b1;
        mem_u.m[39] = 32'hCAFE_0008;
        run(32'h101C_0002, 32'h0000_0082, atfb_pkg::ACK_PENDING, 8);
        chk(got.size(), 2);
        chk({16'h0000, got[0], got[1]}, 32'h0000_1122);
        chk(irqs, 0);
        chk(blks, 8);
        chk(blkw, 32'hCAFE_0008);
        chk(mem_u.m[3], 32'hFFFF_0000);
        slow <= 1'b0;
    endtask : sc_no_update
    task sc_report;
        run(32'h100C_0001, 32'h0, 4'h4, 1);
        chk(irqs, 0);
        resp <= 1'b1;
        run(32'h181C_0001, 32'h0, 4'h4, 1);
        resp <= 1'b0;
        chk(irqs, 1);
        chk(mem_u.m[3], 32'h1234_0000);
        mem_u.m[0] = 32'h001C_0001;
        wr(atfb_pkg::REG_CTRL, 32'h0000_0003);
        repeat (30) @(posedge i_clock);
        rd(atfb_pkg::REG_STATUS, 32'h0000_0242);
        rd(atfb_pkg::REG_DONE, 32'h0000_0004);
    endtask : sc_report
    task summarize;
        $display("checks %0d fails %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : summarize
    initial begin
        #100000;
        fails++;
        summarize();
    end
    initial begin
        repeat (20) @(posedge i_clock);
        i_rst_b <= 1'b1;
        repeat (3) @(posedge i_clock);
        wr(atfb_pkg::REG_PTR, 32'h0);
        sc_update();
        sc_no_update();
        sc_report();
        summarize();
    end
endmodule : test_async_tx_final_buffer_descriptor
